/* File: mfb_consts.svh */
// offsets, field positions and widths of the feature and branch index registers, and the debug control reset value
`ifndef MFB_CONSTS_SVH
`define MFB_CONSTS_SVH

`define MFB_ADDR_W          12
`define MFB_DATA_W          64
`define MFB_OFS_FEATURE     12'h1A0
`define MFB_OFS_TOP_INDEX   12'h1C9
`define MFB_OFS_DEBUG_CTL   12'h1D9
`define MFB_BIT_THERM_EN    3
`define MFB_BIT_PERF_AVAIL  7
`define MFB_BIT_FLOAT_ERROR_OUTPUT_MUX    10
`define MFB_BIT_BTS_NONE    11
`define MFB_BIT_PRECISE_EVENT_SAMPLING_NONE   12
`define MFB_BIT_DVFS_EN     16
`define MFB_BIT_PRIO_DIS    23
`define MFB_FEATURE_WMASK   64'h0000_0000_0081_0408
`define MFB_TOP_INDEX_W     4
`define MFB_DEBUG_RESET     64'h0000_0000_0000_0000

`endif

/* File: mfb_pkg.sv */
// types shared by the feature and branch index register bank
package mfb_pkg;
    typedef enum logic [1:0] {
        MFB_SEL_NONE,
        MFB_SEL_FEATURE,
        MFB_SEL_TOP_INDEX,
        MFB_SEL_DEBUG
    } mfb_sel_t;

    typedef enum logic [1:0] {
        MFB_THERM_OFF,
        MFB_THERM_MOD,
        MFB_THERM_FREQ
    } mfb_therm_t;
endpackage

/* File: mfb_therm_ctl.sv */
// thermal control circuit mode resolver
`timescale 1ns/100ps
`include "mfb_consts.svh"

module mfb_therm_ctl
    import mfb_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       therm_enable,
    input  wire logic       thermal_mode_select,
    input  wire logic       thermal_hot,
    output mfb_therm_t      therm_mode,
    output logic            clock_modulate,
    output logic            freq_step_req
);

    typedef struct packed {
        mfb_therm_t mode;
        logic       modulate;
        logic       freq_req;
    } mfb_therm_state_t;

    mfb_therm_state_t st_ff;
    mfb_therm_state_t nxt_st;

    // ==========================================
    // mode selection
    always_comb
    begin
        nxt_st = st_ff;
        if (!therm_enable)
        begin
            nxt_st.mode = MFB_THERM_OFF;                 // [RL11]
        end
        else if (thermal_mode_select)
        begin
            nxt_st.mode = MFB_THERM_FREQ;
        end
        else
        begin
            nxt_st.mode = MFB_THERM_MOD;
        end
        nxt_st.modulate = thermal_hot && (nxt_st.mode == MFB_THERM_MOD);   // [RL1]
        nxt_st.freq_req = thermal_hot && (nxt_st.mode == MFB_THERM_FREQ);  // [RL1]
    end

    // ==========================================
    // state register
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            st_ff <= '{mode: MFB_THERM_OFF, modulate: 1'b0, freq_req: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign therm_mode     = st_ff.mode;
    assign clock_modulate = st_ff.modulate;
    assign freq_step_req  = st_ff.freq_req;

endmodule

/* File: mfb_regs.sv */
// miscellaneous feature enable, branch record index and debug control registers
`timescale 1ns/100ps
`include "mfb_consts.svh"

// What this block does
// RL1: setting feature bit 3 enables thermal control, modulating clocks or requesting a frequency step from the sensor.
// RL2: feature bit 7 is read-only, 1 when performance monitoring is enabled.
// RL3: feature bit 10 set makes float error output signal pending break events.
// RL4: software must set bit 10 before using the extended interrupt controller.
// RL5: feature bit 11 is read-only, 1 when branch trace storage is absent.
// RL6: feature bit 12 is read-only and always 1, precise sampling absent.
// RL7: feature bit 16 enables voltage-frequency scaling; may be made read-only.
// RL8: feature bit 23 set stops priority messages to the chipset.
// RL9: branch record pointer is read-only; bits 3:0 give newest branch slot.
// RL10: debug control word is fully readable and writable by software.
// RL11: with bit 3 clear, thermal mode select has no effect, monitoring off.
// RL12: reserved feature bits read zero and ignore writes.
module mfb_regs
    import mfb_pkg::*;
#(
    parameter int        TOP_INDEX_W   = `MFB_TOP_INDEX_W,
    parameter bit        PERF_MON_EN   = 1'b1,
    parameter bit        BTS_ABSENT    = 1'b0,
    parameter bit        DVFS_WRITABLE = 1'b1,
    parameter bit        DVFS_RESET    = 1'b0,
    parameter bit        PRIO_DIS_RST  = 1'b0
)
(
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    input  wire logic [`MFB_ADDR_W-1:0]     reg_addr,
    input  wire logic [`MFB_DATA_W-1:0]     reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [`MFB_DATA_W-1:0]     reg_rdata,
    input  wire logic [TOP_INDEX_W-1:0]     branch_top_slot,
    input  wire logic                       thermal_mode_select,
    input  wire logic                       thermal_hot,
    input  wire logic                       break_pending,
    input  wire logic                       legacy_float_error,
    output logic                            float_error_output,
    output logic                            thermal_control_circuit,
    output logic                            clock_modulate,
    output logic                            freq_step_req,
    output logic                            dvfs_enable,
    output logic                            priority_message_enable,
    output logic      [`MFB_DATA_W-1:0]     debug_control_word
);

    typedef struct packed {
        logic                   therm_en;
        logic                   float_error_output_mux;
        logic                   dvfs_en;
        logic                   prio_dis;
        logic                   float_error_output_out;
        logic [`MFB_DATA_W-1:0] debug_ctl;
        logic [`MFB_DATA_W-1:0] rdata;
    } mfb_state_t;

    mfb_state_t st_ff;
    mfb_state_t nxt_st;

    // ==========================================
    // address decode
    function automatic mfb_sel_t decode(input logic [`MFB_ADDR_W-1:0] addr);
        unique case (addr)
            `MFB_OFS_FEATURE:   decode = MFB_SEL_FEATURE;
            `MFB_OFS_TOP_INDEX: decode = MFB_SEL_TOP_INDEX;
            `MFB_OFS_DEBUG_CTL: decode = MFB_SEL_DEBUG;
            default:            decode = MFB_SEL_NONE;
        endcase
    endfunction

    // ==========================================
    // read image of the feature register
    function automatic logic [`MFB_DATA_W-1:0] feature_image(input mfb_state_t s);
        logic [`MFB_DATA_W-1:0] v;
        v = '0;                                          // [RL12]
        v[`MFB_BIT_THERM_EN]   = s.therm_en;
        v[`MFB_BIT_PERF_AVAIL] = PERF_MON_EN;            // [RL2]
        v[`MFB_BIT_FLOAT_ERROR_OUTPUT_MUX]   = s.float_error_output_mux;
        v[`MFB_BIT_BTS_NONE]   = BTS_ABSENT;             // [RL5]
        v[`MFB_BIT_PRECISE_EVENT_SAMPLING_NONE]  = 1'b1;                   // [RL6]
        v[`MFB_BIT_DVFS_EN]    = s.dvfs_en;
        v[`MFB_BIT_PRIO_DIS]   = s.prio_dis;
        feature_image = v;
    endfunction

    mfb_sel_t wsel;
    mfb_sel_t rsel;

    assign wsel = reg_wr ? decode(reg_addr) : MFB_SEL_NONE;
    assign rsel = reg_rd ? decode(reg_addr) : MFB_SEL_NONE;

    // ==========================================
    // next state
    always_comb
    begin
        nxt_st = st_ff;
        if (wsel == MFB_SEL_FEATURE)
        begin
            // only writable fields are taken; read-only and reserved bits ignored
            nxt_st.therm_en = reg_wdata[`MFB_BIT_THERM_EN];        // [RL1]
            nxt_st.float_error_output_mux = reg_wdata[`MFB_BIT_FLOAT_ERROR_OUTPUT_MUX];        // [RL3]
            if (DVFS_WRITABLE)
            begin
                nxt_st.dvfs_en = reg_wdata[`MFB_BIT_DVFS_EN];      // [RL7]
            end
            nxt_st.prio_dis = reg_wdata[`MFB_BIT_PRIO_DIS];        // [RL8]
        end
        if (wsel == MFB_SEL_DEBUG)
        begin
            nxt_st.debug_ctl = reg_wdata;                          // [RL10]
        end
        // float error pin: break event or legacy signalling
        nxt_st.float_error_output_out = st_ff.float_error_output_mux ? break_pending : legacy_float_error;   // [RL3]
        unique case (rsel)
            MFB_SEL_FEATURE:   nxt_st.rdata = feature_image(st_ff);
            MFB_SEL_TOP_INDEX: nxt_st.rdata = {{(`MFB_DATA_W-TOP_INDEX_W){1'b0}},
                                               branch_top_slot};  // [RL9]
            MFB_SEL_DEBUG:     nxt_st.rdata = st_ff.debug_ctl;     // [RL10]
            MFB_SEL_NONE:      nxt_st.rdata = '0;
        endcase
    end

    // ==========================================
    // state register
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            st_ff <= '{therm_en:  1'b0,
                       float_error_output_mux:  1'b0,
                       dvfs_en:   DVFS_RESET,
                       prio_dis:  PRIO_DIS_RST,
                       float_error_output_out:  1'b0,
                       debug_ctl: `MFB_DEBUG_RESET,
                       rdata:     '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================
    // thermal control
    mfb_therm_ctl u_therm
    (
        .sys_clk             (sys_clk),
        .resetn              (resetn),
        .therm_enable        (st_ff.therm_en),             // [RL11]
        .thermal_mode_select (thermal_mode_select),
        .thermal_hot         (thermal_hot),
        .therm_mode          (),
        .clock_modulate      (clock_modulate),
        .freq_step_req       (freq_step_req)
    );

    assign reg_rdata               = st_ff.rdata;
    assign float_error_output      = st_ff.float_error_output_out;
    assign thermal_control_circuit = st_ff.therm_en;       // [RL1]
    assign dvfs_enable             = st_ff.dvfs_en;        // [RL7]
    assign priority_message_enable = ~st_ff.prio_dis;      // [RL8]
    assign debug_control_word      = st_ff.debug_ctl;

endmodule

/* File: mfb_regs_properties.sv */
// concurrent checks on the feature and branch index register bank
`timescale 1ns/100ps
`include "mfb_consts.svh"

module mfb_props
    import mfb_pkg::*;
#(parameter int TOP_INDEX_W = 4)
(
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    input wire logic [11:0]            reg_addr,
    input wire logic [63:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [63:0]            reg_rdata,
    input wire logic [TOP_INDEX_W-1:0] branch_top_slot,
    input wire logic                   thermal_mode_select,
    input wire logic                   thermal_hot,
    input wire logic                   break_pending,
    input wire logic                   legacy_float_error,
    input wire logic                   float_error_output,
    input wire logic                   thermal_control_circuit,
    input wire logic                   clock_modulate,
    input wire logic                   freq_step_req,
    input wire logic                   dvfs_enable,
    input wire logic                   priority_message_enable,
    input wire logic [63:0]            debug_control_word
);
    // ==========================================
    // helper: shadow of the float error mux bit
    logic mux_ff;
    wire  wf = reg_wr && (reg_addr == `MFB_OFS_FEATURE);
    wire  rf = reg_rd && (reg_addr == `MFB_OFS_FEATURE);
    always_ff @(posedge sys_clk)
        mux_ff <= !resetn ? 1'b0 : (wf ? reg_wdata[10] : mux_ff);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // assertions
    a_therm_enable: assert property (wf |=> thermal_control_circuit == $past(reg_wdata[3]))
        else $error("thermal enable mismatch");
    a_ro_flags: assert property (rf |=> reg_rdata[12:11] == 2'h2 && reg_rdata[7])
        else $error("read-only flags wrong");
    a_float_mux: assert property ($past(resetn) |->
        float_error_output == $past(mux_ff ? break_pending : legacy_float_error))
        else $error("float error output wrong");
    a_dvfs_bit: assert property (wf |=> dvfs_enable == $past(reg_wdata[16]))
        else $error("dvfs enable mismatch");
    a_prio_disable: assert property (wf |=> priority_message_enable != $past(reg_wdata[23]))
        else $error("priority message enable mismatch");
    a_index_read: assert property (reg_rd && reg_addr == `MFB_OFS_TOP_INDEX |=>
        reg_rdata == 64'($past(branch_top_slot)))
        else $error("index read mismatch");
    a_debug_write: assert property (reg_wr && reg_addr == `MFB_OFS_DEBUG_CTL |=>
        debug_control_word == $past(reg_wdata))
        else $error("debug word mismatch");
    a_therm_off: assert property (!thermal_control_circuit |=> !clock_modulate && !freq_step_req)
        else $error("thermal action while disabled");
    a_reserved_zero: assert property (rf |=> (reg_rdata & ~64'h81_1C88) == 64'h0)
        else $error("reserved bits not zero");
endmodule

bind mfb_regs mfb_props #(.TOP_INDEX_W(TOP_INDEX_W)) i_props (.*);

/* File: tb_top.sv */
// self-checking bench for the feature and branch index register bank
`timescale 1ns/100ps
`include "mfb_consts.svh"

module tb_top;
    import mfb_pkg::*;
    logic        sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
    logic [11:0] reg_addr = 12'h0;
    logic [63:0] reg_wdata = 64'h0, reg_rdata, debug_control_word;
    logic [3:0]  branch_top_slot = 4'h0;
    logic        thermal_mode_select = 0, thermal_hot = 0, break_pending = 1, legacy_float_error = 0;
    logic        float_error_output, thermal_control_circuit, clock_modulate, freq_step_req;
    logic        dvfs_enable, priority_message_enable;
    int          n_fail = 0, n_tests = 0;
    localparam logic [11:0] FE = `MFB_OFS_FEATURE;
    localparam logic [11:0] TI = `MFB_OFS_TOP_INDEX;
    localparam logic [11:0] DC = `MFB_OFS_DEBUG_CTL;
    always #5 sys_clk = ~sys_clk;
    mfb_regs i_dut (.*);
    // ==========================================
    // bus and compare tasks
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [63:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rc(input logic [11:0] a, input logic [63:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", e, reg_rdata);
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_feature();
        rc(FE, 64'h1080);
        chk("prio", 64'h1, 64'(priority_message_enable));
        wr(FE, 64'hFFFF_FFFF_FFFF_FFFF);
        chk("tcc", 64'h1, 64'(thermal_control_circuit));
        chk("dvfs", 64'h1, 64'(dvfs_enable));
        chk("prio", 64'h0, 64'(priority_message_enable));
        rc(FE, 64'h81_1488);
        settle();
        chk("float_error_output", 64'h1, 64'(float_error_output));
        @(posedge sys_clk);
        break_pending      <= 1'b0;
        legacy_float_error <= 1'b1;
        settle();
        chk("float_error_output", 64'h0, 64'(float_error_output));
        wr(FE, 64'h0);
        settle();
        chk("float_error_output", 64'h1, 64'(float_error_output));
        @(posedge sys_clk) legacy_float_error <= 1'b0;
        settle();
        chk("float_error_output", 64'h0, 64'(float_error_output));
        $display("t_feature done");
    endtask
    task automatic t_therm();
        @(posedge sys_clk) thermal_hot <= 1'b1;
        settle();
        chk("clkmod", 64'h0, 64'({clock_modulate, freq_step_req}));
        @(posedge sys_clk) thermal_mode_select <= 1'b1;
        settle();
        chk("freq", 64'h0, 64'({clock_modulate, freq_step_req}));
        wr(FE, 64'h8);
        settle();
        chk("freq", 64'h1, 64'({clock_modulate, freq_step_req}));
        @(posedge sys_clk) thermal_mode_select <= 1'b0;
        settle();
        chk("clkmod", 64'h2, 64'({clock_modulate, freq_step_req}));
        $display("t_therm done");
    endtask
    task automatic t_index_debug();
        @(posedge sys_clk) branch_top_slot <= 4'hF;
        rc(TI, 64'hF);
        @(posedge sys_clk) branch_top_slot <= 4'hA;
        wr(TI, 64'h5);
        rc(TI, 64'hA);
        wr(DC, 64'hDEAD_BEEF_0123_4567);
        chk("debug", 64'hDEAD_BEEF_0123_4567, debug_control_word);
        rc(DC, 64'hDEAD_BEEF_0123_4567);
        wr(12'h1A1, 64'hFFFF_FFFF_FFFF_FFFF);
        rc(12'h1A1, 64'h0);
        rc(FE, 64'h1088);
        $display("t_index_debug done");
    endtask
    task automatic t_reset();
        @(posedge sys_clk) resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 chk("debug", `MFB_DEBUG_RESET, debug_control_word);
        chk("tcc", 64'h0, 64'(thermal_control_circuit));
        chk("dvfs", 64'h0, 64'(dvfs_enable));
        chk("prio", 64'h1, 64'(priority_message_enable));
        chk("clkmod", 64'h0, 64'({clock_modulate, freq_step_req}));
        rc(FE, 64'h1080);
        $display("t_reset done");
    endtask
    initial
    begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        t_feature();
        t_therm();
        t_index_debug();
        t_reset();
        stop_test();
    end
endmodule
